// [src/rts_sequencer.sv]
// reset timeout sequencer with cause flags and register slave
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/10ps
module rts_sequencer
    import rts_pkg::*;
#(
    parameter int POWERUP_TICKS_P = POWERUP_TICKS
) (
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    // analogue monitors and pins
    input  wire logic        power_on_i,
    input  wire logic        brownout_i,
    input  wire logic        supply_good_i,
    input  wire logic        ext_clear_n_i,
    input  wire logic        osc_clk_i,
    input  wire logic        rc_clk_i,
    // core side, same clock
    input  wire logic        watchdog_i,
    input  wire logic        sleep_i,
    input  wire logic        wake_irq_i,
    input  wire logic        global_irq_enable_i,
    input  wire logic [12:0] pc_i,
    output logic             core_reset_o,
    output logic             exec_hold_o,
    output logic             pc_load_o,
    output logic [12:0]      pc_value_o,
    output logic             clock_speed_select_o,
    // avalon-mm slave
    input  wire logic [9:0]  address_i,
    input  wire logic        read_i,
    input  wire logic        write_i,
    input  wire logic [31:0] writedata_i,
    input  wire logic [3:0]  byteenable_i,
    output logic [31:0]      readdata_o,
    output logic             waitrequest_o
);

    // ==========================================================
    // helpers
    function automatic logic is_crystal(input logic [2:0] mode);
        is_crystal = (mode == MODE_LOW_POWER_CRYSTAL) | (mode == MODE_CRYSTAL)
                   | (mode == MODE_HIGH_SPEED_CRYSTAL);
    endfunction : is_crystal

    function automatic logic is_reset_state(input rts_state_t st);
        is_reset_state = (st == ST_WAIT_SUPPLY) | (st == ST_DELAY)
                       | (st == ST_STARTUP) | (st == ST_WAIT_PIN);
    endfunction : is_reset_state

    // ==========================================================
    // pin synchronisers
    logic power_on_lvl;
    logic brownout_lvl;
    logic supply_lvl;
    logic pin_lvl;
    logic osc_rise;
    logic rc_rise;

    rts_pin_sync #(.RESET_VAL(1'b1)) u_power_on (
        .clk_i   (clk_i),
        .resetn_i(resetn_i),
        .pin_i   (power_on_i),
        .level_o (power_on_lvl),
        .rise_o  ()
    );
    rts_pin_sync #(.RESET_VAL(1'b0)) u_brownout (
        .clk_i   (clk_i),
        .resetn_i(resetn_i),
        .pin_i   (brownout_i),
        .level_o (brownout_lvl),
        .rise_o  ()
    );
    rts_pin_sync #(.RESET_VAL(1'b0)) u_supply (
        .clk_i   (clk_i),
        .resetn_i(resetn_i),
        .pin_i   (supply_good_i),
        .level_o (supply_lvl),
        .rise_o  ()
    );
    rts_pin_sync #(.RESET_VAL(1'b0)) u_clear_pin (
        .clk_i   (clk_i),
        .resetn_i(resetn_i),
        .pin_i   (ext_clear_n_i),
        .level_o (pin_lvl),
        .rise_o  ()
    );
    // oscillator is sampled, so it must stay at or below a quarter of clk_i
    rts_pin_sync #(.RESET_VAL(1'b0)) u_osc_clk (
        .clk_i   (clk_i),
        .resetn_i(resetn_i),
        .pin_i   (osc_clk_i),
        .level_o (),
        .rise_o  (osc_rise)
    );
    rts_pin_sync #(.RESET_VAL(1'b0)) u_rc_clk (
        .clk_i   (clk_i),
        .resetn_i(resetn_i),
        .pin_i   (rc_clk_i),
        .level_o (),
        .rise_o  (rc_rise)
    );

    // ==========================================================
    // registers
    rts_state_t  state_reg;
    rts_state_t  state_next;
    rts_cause_t  cause_reg;
    rts_cause_t  cause_next;
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    logic [11:0] dip_cnt_reg;
    logic [11:0] dip_cnt_next;
    logic [2:0]  mode_reg;
    logic        delay_dis_reg;
    logic        dip_en_reg;
    logic        expiry_reg;
    logic        expiry_next;
    logic        sleep_flag_reg;
    logic        sleep_flag_next;
    logic        bo_flag_reg;
    logic        bo_flag_next;
    logic        pon_flag_reg;
    logic        pon_flag_next;
    logic        speed_next;
    logic        pc_load_next;
    logic [12:0] pc_value_next;
    logic        irq_vec_reg;
    logic        irq_vec_next;

    // ==========================================================
    // decode
    wire logic dip_trip;
    wire logic in_sleep;
    wire logic in_run;
    wire logic reset_take;
    wire logic wake_take;
    wire logic crystal;
    wire logic delay_done;
    wire logic startup_done;
    wire logic startup_needed;
    wire logic bus_req;
    wire logic bus_wr;
    wire logic wr_power;
    wire logic wr_config;
    wire logic [7:0] rd_byte;
    wire rts_state_t after_delay;

    assign crystal  = is_crystal(mode_reg);
    assign in_run   = (state_reg == ST_RUN) | (state_reg == ST_VECTOR);
    assign in_sleep = (state_reg == ST_SLEEP) | (state_reg == ST_WAKE_STARTUP);

    assign dip_trip = dip_en_reg & brownout_lvl
                    & (dip_cnt_reg == 12'(BROWNOUT_CYCLES - 1));

    assign reset_take = power_on_lvl | dip_trip
                      | (~pin_lvl & (in_run | in_sleep))
                      | (watchdog_i & in_run);
    assign wake_take  = (state_reg == ST_SLEEP) & (watchdog_i | wake_irq_i);

    assign delay_done   = rc_rise & (cnt_reg == 16'(POWERUP_TICKS_P - 1));
    assign startup_done = osc_rise & (cnt_reg == 16'(STARTUP_CYCLES - 1));
    // start-up count only for crystals after power-on
    assign startup_needed = crystal & (cause_reg == CAUSE_POWER_ON);
    // strict order: delay, then start-up count, then clear pin
    assign after_delay = startup_needed ? ST_STARTUP : ST_WAIT_PIN;

    assign bus_req   = read_i | write_i;
    assign bus_wr    = write_i & ~waitrequest_o & byteenable_i[0];
    assign wr_power  = bus_wr & (address_i == POWER_CTRL_ADDR);
    assign wr_config = bus_wr & (address_i == SEQ_CONFIG_ADDR);

    assign rd_byte =
        (address_i == CORE_STATUS_ADDR) ?
            8'((expiry_reg << WATCHDOG_EXPIRY_BIT) | (sleep_flag_reg << SLEEP_ENTRY_BIT)) :
        (address_i == POWER_CTRL_ADDR) ?
            8'((clock_speed_select_o << CLOCK_SPEED_BIT)
               | (pon_flag_reg << POWER_ON_FLAG_BIT)
               | (bo_flag_reg << BROWNOUT_FLAG_BIT)) :
        (address_i == SEQ_CONFIG_ADDR) ?
            8'((dip_en_reg << CFG_DIP_EN_BIT) | (delay_dis_reg << CFG_DELAY_DIS_BIT)
               | (mode_reg << CFG_MODE_LSB)) :
            8'h00;

    assign dip_cnt_next = (!brownout_lvl || dip_trip) ? 12'h000 : dip_cnt_reg + 12'h001;

    // ==========================================================
    // sequence
    always_comb begin
        state_next    = state_reg;
        cause_next    = cause_reg;
        cnt_next      = cnt_reg;
        pc_load_next  = 1'b0;
        pc_value_next = pc_value_o;
        irq_vec_next  = irq_vec_reg;
        if (reset_take) begin
            // brown-out at any point, delay included, restarts from supply wait
            state_next = ST_WAIT_SUPPLY;
            cnt_next   = 16'h0000;
            if (power_on_lvl) begin
                cause_next = CAUSE_POWER_ON;
            end else if (dip_trip) begin
                cause_next = CAUSE_BROWNOUT;
            end else if (!pin_lvl) begin
                cause_next = in_sleep ? CAUSE_PIN_SLEEP : CAUSE_PIN_RUN;
            end else begin
                cause_next = CAUSE_WATCHDOG;
            end
        end else begin
            unique case (state_reg)
                ST_WAIT_SUPPLY: begin
                    // hold until supply good and the power-on pulse is over
                    if (supply_lvl) begin
                        cnt_next   = 16'h0000;
                        // no delay and no crystal leaves no timeout at all
                        state_next = delay_dis_reg ? after_delay : ST_DELAY;
                    end
                end
                ST_DELAY: begin
                    if (delay_done) begin
                        cnt_next   = 16'h0000;
                        state_next = after_delay;
                    end else if (rc_rise) begin
                        cnt_next = cnt_reg + 16'h0001;
                    end
                end
                ST_STARTUP: begin
                    if (startup_done) begin
                        state_next = ST_WAIT_PIN;
                    end else if (osc_rise) begin
                        cnt_next = cnt_reg + 16'h0001;
                    end
                end
                ST_WAIT_PIN: begin
                    // delays already ran once power-on was over and supply was good, pin low or not
                    if (pin_lvl) begin
                        state_next    = ST_RUN;
                        pc_load_next  = 1'b1;
                        pc_value_next = RESET_VECTOR;
                    end
                end
                ST_RUN: begin
                    if (sleep_i) begin
                        state_next = ST_SLEEP;
                    end
                end
                ST_SLEEP: begin
                    if (wake_take) begin
                        cause_next   = watchdog_i ? CAUSE_WATCHDOG_WAKE : CAUSE_IRQ_WAKE;
                        irq_vec_next = ~watchdog_i & global_irq_enable_i;
                        cnt_next     = 16'h0000;
                        if (crystal) begin
                            state_next = ST_WAKE_STARTUP;
                        end else begin
                            state_next    = irq_vec_next ? ST_VECTOR : ST_RUN;
                            pc_load_next  = 1'b1;
                            pc_value_next = pc_i + 13'h0001;
                        end
                    end
                end
                ST_WAKE_STARTUP: begin
                    if (startup_done) begin
                        state_next    = irq_vec_reg ? ST_VECTOR : ST_RUN;
                        pc_load_next  = 1'b1;
                        pc_value_next = pc_i + 13'h0001;
                    end else if (osc_rise) begin
                        cnt_next = cnt_reg + 16'h0001;
                    end
                end
                ST_VECTOR: begin
                    state_next    = ST_RUN;
                    irq_vec_next  = 1'b0;
                    pc_load_next  = 1'b1;
                    pc_value_next = IRQ_VECTOR;
                end
            endcase
        end
    end

    // ==========================================================
    // cause flags: hardware cause wins over a same-cycle software write
    always_comb begin
        expiry_next     = expiry_reg;
        sleep_flag_next = sleep_flag_reg;
        bo_flag_next    = wr_power ? writedata_i[BROWNOUT_FLAG_BIT] : bo_flag_reg;
        pon_flag_next   = wr_power ? writedata_i[POWER_ON_FLAG_BIT] : pon_flag_reg;
        speed_next      = wr_power ? writedata_i[CLOCK_SPEED_BIT] : clock_speed_select_o;
        if (state_reg == ST_RUN && sleep_i && !reset_take) begin
            sleep_flag_next = 1'b0;
        end
        if (reset_take) begin
            speed_next = CLOCK_SPEED_RST;
            unique case (cause_next)
                CAUSE_POWER_ON: begin
                    pon_flag_next   = 1'b0;
                    expiry_next     = 1'b1;
                    sleep_flag_next = 1'b1;
                end
                // only reachable with detection on; off leaves the flag stale
                CAUSE_BROWNOUT:  bo_flag_next = 1'b0;
                CAUSE_PIN_SLEEP: begin
                    expiry_next     = 1'b1;
                    sleep_flag_next = 1'b0;
                end
                CAUSE_WATCHDOG:  expiry_next = 1'b0;
                default: begin
                end
            endcase
        end else if (wake_take) begin
            expiry_next     = ~watchdog_i;
            sleep_flag_next = 1'b0;
        end
    end

    // ==========================================================
    // flip-flops
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg   <= ST_WAIT_SUPPLY;
            cause_reg   <= CAUSE_POWER_ON;
            cnt_reg     <= 16'h0000;
            dip_cnt_reg <= 12'h000;
            irq_vec_reg <= 1'b0;
        end else begin
            state_reg   <= state_next;
            cause_reg   <= cause_next;
            cnt_reg     <= cnt_next;
            dip_cnt_reg <= dip_cnt_next;
            irq_vec_reg <= irq_vec_next;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            expiry_reg           <= WATCHDOG_EXPIRY_RST;
            sleep_flag_reg       <= SLEEP_ENTRY_RST;
            bo_flag_reg          <= BROWNOUT_FLAG_RST;
            pon_flag_reg         <= POWER_ON_FLAG_RST;
            clock_speed_select_o <= CLOCK_SPEED_RST;
        end else begin
            expiry_reg           <= expiry_next;
            sleep_flag_reg       <= sleep_flag_next;
            bo_flag_reg          <= bo_flag_next;
            pon_flag_reg         <= pon_flag_next;
            clock_speed_select_o <= speed_next;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mode_reg      <= MODE_RST;
            delay_dis_reg <= DELAY_DISABLE_RST;
            dip_en_reg    <= DIP_ENABLE_RST;
        end else if (wr_config) begin
            mode_reg      <= writedata_i[CFG_MODE_LSB +: 3];
            delay_dis_reg <= writedata_i[CFG_DELAY_DIS_BIT];
            dip_en_reg    <= writedata_i[CFG_DIP_EN_BIT];
        end
    end

    // ==========================================================
    // outputs and bus answer: one wait cycle, then one cycle with waitrequest low
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            core_reset_o  <= 1'b1;
            exec_hold_o   <= 1'b1;
            pc_load_o     <= 1'b0;
            pc_value_o    <= RESET_VECTOR;
            waitrequest_o <= 1'b1;
            readdata_o    <= 32'h0000_0000;
        end else begin
            core_reset_o  <= is_reset_state(state_next);
            exec_hold_o   <= (state_next != ST_RUN);
            pc_load_o     <= pc_load_next;
            pc_value_o    <= pc_value_next;
            waitrequest_o <= ~(bus_req & waitrequest_o);
            readdata_o    <= {24'h000000, rd_byte};
        end
    end

endmodule : rts_sequencer

// [pkg/rts_pkg.sv]
// constants and types of the reset timeout sequencer
package rts_pkg;

    // ==========================================================
    // clock and timing
    localparam int CLK_PERIOD_NS  = 50;
    localparam int BROWNOUT_MIN_NS = 100000;
    localparam int BROWNOUT_CYCLES = (BROWNOUT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POWERUP_DELAY_US = 72000;
    localparam int RC_NOMINAL_HZ    = 100000;
    localparam int POWERUP_TICKS    = POWERUP_DELAY_US * (RC_NOMINAL_HZ / 1000) / 1000;
    localparam int STARTUP_CYCLES   = 1024;

    // ==========================================================
    // register map: printed offsets are indices, byte address is four times
    localparam logic [7:0] CORE_STATUS_IDX = 8'h03;
    localparam logic [7:0] POWER_CTRL_IDX  = 8'h8E;
    localparam logic [7:0] SEQ_CONFIG_IDX  = 8'h90;
    localparam logic [9:0] CORE_STATUS_ADDR = {CORE_STATUS_IDX, 2'b00};
    localparam logic [9:0] POWER_CTRL_ADDR  = {POWER_CTRL_IDX, 2'b00};
    localparam logic [9:0] SEQ_CONFIG_ADDR  = {SEQ_CONFIG_IDX, 2'b00};

    // ==========================================================
    // field positions
    localparam int WATCHDOG_EXPIRY_BIT = 4;
    localparam int SLEEP_ENTRY_BIT     = 3;
    localparam int BROWNOUT_FLAG_BIT   = 0;
    localparam int POWER_ON_FLAG_BIT   = 1;
    localparam int CLOCK_SPEED_BIT     = 3;
    localparam int CFG_MODE_LSB        = 0;
    localparam int CFG_DELAY_DIS_BIT   = 3;
    localparam int CFG_DIP_EN_BIT      = 4;

    // ==========================================================
    // reset values
    localparam logic       BROWNOUT_FLAG_RST   = 1'b0;
    localparam logic       POWER_ON_FLAG_RST   = 1'b0;
    localparam logic       CLOCK_SPEED_RST     = 1'b1;
    localparam logic       WATCHDOG_EXPIRY_RST = 1'b1;
    localparam logic       SLEEP_ENTRY_RST     = 1'b1;
    localparam logic       DELAY_DISABLE_RST   = 1'b0;
    localparam logic       DIP_ENABLE_RST      = 1'b1;

    // ==========================================================
    // program counter targets
    localparam logic [12:0] RESET_VECTOR = 13'h0000;
    localparam logic [12:0] IRQ_VECTOR   = 13'h0004;

    // ==========================================================
    // oscillator modes
    localparam logic [2:0] MODE_LOW_POWER_CRYSTAL  = 3'h0;
    localparam logic [2:0] MODE_CRYSTAL            = 3'h1;
    localparam logic [2:0] MODE_HIGH_SPEED_CRYSTAL = 3'h2;
    localparam logic [2:0] MODE_EXTERNAL_CLOCK     = 3'h3;
    localparam logic [2:0] MODE_INTERNAL_CLOCK     = 3'h4;
    localparam logic [2:0] MODE_RESISTOR_CAP       = 3'h5;
    localparam logic [2:0] MODE_RST                = MODE_CRYSTAL;

    typedef enum logic [2:0] {
        CAUSE_POWER_ON,
        CAUSE_BROWNOUT,
        CAUSE_PIN_RUN,
        CAUSE_PIN_SLEEP,
        CAUSE_WATCHDOG,
        CAUSE_WATCHDOG_WAKE,
        CAUSE_IRQ_WAKE
    } rts_cause_t;

    typedef enum logic [2:0] {
        ST_WAIT_SUPPLY,
        ST_DELAY,
        ST_STARTUP,
        ST_WAIT_PIN,
        ST_RUN,
        ST_SLEEP,
        ST_WAKE_STARTUP,
        ST_VECTOR
    } rts_state_t;

endpackage : rts_pkg

// [src/rts_pin_sync.sv]
// three-stage pin synchroniser with agreement filter and rise pulse
`timescale 1ns/10ps
module rts_pin_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input  wire logic clk_i,
    input  wire logic resetn_i,
    input  wire logic pin_i,
    output logic      level_o,
    output logic      rise_o
);
    logic meta_reg;
    logic sync_reg;
    logic late_reg;
    logic agree;

    // a change only counts once the last two stages agree
    assign agree = (sync_reg == late_reg);

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta_reg <= RESET_VAL;
            sync_reg <= RESET_VAL;
            late_reg <= RESET_VAL;
            level_o  <= RESET_VAL;
            rise_o   <= 1'b0;
        end else begin
            meta_reg <= pin_i;
            sync_reg <= meta_reg;
            late_reg <= sync_reg;
            if (agree) begin
                level_o <= late_reg;
            end
            rise_o <= agree & late_reg & ~level_o;
        end
    end
endmodule : rts_pin_sync

// [sim/rts_sequencer_chk.sv]
// port assertions of the reset timeout sequencer
`timescale 1ns/10ps
module rts_sequencer_chk
    import rts_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        resetn_i,
    input wire logic        power_on_i,
    input wire logic        ext_clear_n_i,
    input wire logic        read_i,
    input wire logic        write_i,
    input wire logic        core_reset_o,
    input wire logic        exec_hold_o,
    input wire logic        pc_load_o,
    input wire logic [12:0] pc_value_o,
    input wire logic [31:0] readdata_o,
    input wire logic        waitrequest_o
);
    // ==========================================
    // bus and sequence relations
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    property p_ans; $rose(read_i || write_i) |-> ##1 !waitrequest_o; endproperty
    a_ans: assert property (p_ans) else $error("bus answer late");
    property p_one; $fell(waitrequest_o) |=> waitrequest_o; endproperty
    a_one: assert property (p_one) else $error("answer too long");
    property p_hi0; !waitrequest_o |-> readdata_o[31:8] == 24'h0; endproperty
    a_hi0: assert property (p_hi0) else $error("upper read bits set");
    property p_vec; $fell(core_reset_o) |-> ##[0:1] (pc_load_o && pc_value_o == RESET_VECTOR);
    endproperty
    a_vec: assert property (p_vec) else $error("no reset vector");
    property p_fall; $fell(core_reset_o) |-> $fell(exec_hold_o); endproperty
    a_fall: assert property (p_fall) else $error("hold not released");
    property p_hold; core_reset_o |-> exec_hold_o; endproperty
    a_hold: assert property (p_hold) else $error("run during reset");
    property p_por; power_on_i [*8] |-> core_reset_o; endproperty
    a_por: assert property (p_por) else $error("power-on ignored");
    property p_pin; !ext_clear_n_i [*8] |-> core_reset_o; endproperty
    a_pin: assert property (p_pin) else $error("clear pin ignored");
endmodule : rts_sequencer_chk

// [sim/rts_partner.sv]
// crystal, rc clock and clear pin model facing the sequencer
`timescale 1ns/10ps
module rts_partner (
    input  wire logic clk_i,
    input  wire logic pin_low_i,
    output logic      osc_clk_o,
    output logic      rc_clk_o,
    output logic      ext_clear_n_o
);
    logic [2:0] div_reg = 3'h0;
    // crystal runs free at 1/8 of clk, below the quarter-rate sampling limit
    always_ff @(posedge clk_i) div_reg <= div_reg + 3'h1;
    assign osc_clk_o     = div_reg[2];
    assign rc_clk_o      = div_reg[1];
    assign ext_clear_n_o = !pin_low_i;
endmodule : rts_partner

// [sim/rts_sequencer_tb.sv]
// self-checking bench of the reset timeout sequencer
`timescale 1ns/10ps
module rts_sequencer_tb
    import rts_pkg::*;
;
    logic clk_i, resetn_i, power_on_i, brownout_i, supply_good_i, pin_low, watchdog_i;
    logic osc_clk_i, rc_clk_i, ext_clear_n_i, sleep_i, wake_irq_i, global_irq_enable_i;
    logic core_reset_o, exec_hold_o, pc_load_o, clock_speed_select_o;
    logic read_i, write_i, waitrequest_o;
    logic [3:0]  byteenable_i;
    logic [9:0]  address_i;
    logic [12:0] pc_i, pc_value_o;
    logic [31:0] writedata_i, readdata_o, rd;
    int          fail_count = 0, checked = 0, n;
    // delay shortened to 10 rc ticks (40 clk cycles)
    rts_sequencer #(.POWERUP_TICKS_P(10)) dut (.*);
    rts_partner u_far (.clk_i, .pin_low_i(pin_low), .osc_clk_o(osc_clk_i),
                       .rc_clk_o(rc_clk_i), .ext_clear_n_o(ext_clear_n_i));
    // ==========================================
    // tasks
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : give_verdict
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic tick(input int k);
        repeat (k) @(posedge clk_i);
    endtask : tick
    task automatic bus(input logic we, input logic [9:0] a, input logic [7:0] d);
        int t = 0;
        read_i <= !we;
        write_i <= we;
        address_i <= a;
        writedata_i <= {24'h0, d};
        @(posedge clk_i);
        while (waitrequest_o !== 1'b0 && t < 50) begin
            @(posedge clk_i);
            t++;
        end
        rd = readdata_o;
        chk("bus wait", 32'h1, {31'h0, t < 50});
        read_i <= 1'b0;
        write_i <= 1'b0;
        @(posedge clk_i);
        if (t >= 50) give_verdict();
    endtask : bus
    task automatic rdc(input logic [9:0] a, input logic [7:0] e, input string s);
        bus(1'b0, a, 8'h00);
        chk(s, {24'h0, e}, rd);
    endtask : rdc
    task automatic wait_run(input int lim);
        n = 0;
        while (core_reset_o !== 1'b0 && n < lim) begin
            @(posedge clk_i);
            n++;
        end
        chk("run", 32'h1, {31'h0, n < lim});
        if (n >= lim) give_verdict();
    endtask : wait_run
    task automatic wait_pc(input logic [12:0] e, input int lim);
        n = 0;
        @(posedge clk_i);
        while (pc_load_o !== 1'b1 && n < lim) begin
            @(posedge clk_i);
            n++;
        end
        chk("pc", {19'h0, e}, (n < lim) ? {19'h0, pc_value_o} : 32'hFFFFFFFF);
        if (n >= lim) give_verdict();
    endtask : wait_pc
    // ==========================================
    // sequence
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    initial begin
        {resetn_i, brownout_i, pin_low, watchdog_i, sleep_i, wake_irq_i} = 6'h00;
        {power_on_i, supply_good_i, global_irq_enable_i} = 3'h7;
        {read_i, write_i, address_i, writedata_i} = 44'h0;
        byteenable_i = 4'hF;
        pc_i = 13'h0123;
        tick(10);
        resetn_i <= 1'b1;
        tick(2);
        rdc(CORE_STATUS_ADDR, 8'h18, "status");
        rdc(POWER_CTRL_ADDR, 8'h08, "power_control_status");
        rdc(10'h100, 8'h00, "unmapped");
        bus(1'b1, SEQ_CONFIG_ADDR, 8'h1D); // rc mode, no delay
        power_on_i <= 1'b0;
        wait_run(12);
        bus(1'b1, POWER_CTRL_ADDR, 8'h0B);
        rdc(POWER_CTRL_ADDR, 8'h0B, "power_control_status set");
        bus(1'b1, SEQ_CONFIG_ADDR, 8'h11); // crystal, delay on
        power_on_i <= 1'b1;
        tick(8);
        power_on_i <= 1'b0;
        wait_run(12000);
        chk("por time", 32'h1, {31'h0, n >= 8200});
        bus(1'b0, POWER_CTRL_ADDR, 8'h00);
        chk("power_control_status por", 32'h08, rd & 32'hFE);
        bus(1'b1, POWER_CTRL_ADDR, 8'h0B);
        for (int en = 0; en < 2; en++) begin
            bus(1'b1, SEQ_CONFIG_ADDR, en ? 8'h11 : 8'h01);
            brownout_i <= 1'b1;
            supply_good_i <= 1'b0;
            tick(2100);
            chk("dip", en, core_reset_o);
            brownout_i <= 1'b0;
            supply_good_i <= 1'b1;
        end
        wait_run(8000);
        chk("bor time", 32'h1, {31'h0, n >= 36});
        rdc(POWER_CTRL_ADDR, 8'h0A, "power_control_status bor");
        bus(1'b1, SEQ_CONFIG_ADDR, 8'h15); // rc mode, delay on
        watchdog_i <= 1'b1;
        tick(1);
        watchdog_i <= 1'b0;
        tick(3);
        wait_run(200);
        rdc(CORE_STATUS_ADDR, 8'h08, "wdt status");
        pin_low <= 1'b1;
        tick(100);
        chk("pin", 32'h1, core_reset_o);
        pin_low <= 1'b0;
        wait_run(8);
        rdc(CORE_STATUS_ADDR, 8'h08, "pin status");
        sleep_i <= 1'b1;
        tick(1);
        sleep_i <= 1'b0;
        tick(2);
        chk("sleep hold", 32'h1, exec_hold_o);
        rdc(CORE_STATUS_ADDR, 8'h00, "sleep status");
        wake_irq_i <= 1'b1;
        tick(1);
        wake_irq_i <= 1'b0;
        wait_pc(13'h0124, 40);
        wait_pc(IRQ_VECTOR, 40);
        rdc(CORE_STATUS_ADDR, 8'h10, "irq wake status");
        bus(1'b1, SEQ_CONFIG_ADDR, 8'h10); // low-power crystal, delay on
        sleep_i <= 1'b1;
        tick(1);
        sleep_i <= 1'b0;
        watchdog_i <= 1'b1;
        tick(1);
        watchdog_i <= 1'b0;
        wait_pc(13'h0124, 9000);
        chk("wake time", 32'h1, {31'h0, n >= 8100});
        rdc(CORE_STATUS_ADDR, 8'h00, "wdt wake status");
        bus(1'b1, POWER_CTRL_ADDR, 8'h03);
        chk("speed", 32'h0, {31'h0, clock_speed_select_o});
        sleep_i <= 1'b1;
        tick(1);
        sleep_i <= 1'b0;
        pin_low <= 1'b1;
        tick(100);
        pin_low <= 1'b0;
        wait_run(100);
        rdc(CORE_STATUS_ADDR, 8'h10, "pin sleep status");
        chk("speed", 32'h1, {31'h0, clock_speed_select_o});
        give_verdict();
    end
endmodule : rts_sequencer_tb
bind rts_sequencer rts_sequencer_chk u_chk (.*);
